// *** pcw_defines.svh ***
// Register offsets and reset values of the port control register window.
// Assumes offsets are taken relative to the window base.
`ifndef PCW_DEFINES_SVH
`define PCW_DEFINES_SVH
`define PCW_WIN_BYTES 9'h100
`define PCW_A_IN 8'h00
`define PCW_B_IN 8'h01
`define PCW_A_OUT 8'h04
`define PCW_B_OUT 8'h05
`define PCW_A_DIR 8'h06
`define PCW_B_DIR 8'h07
`define PCW_A_DRV 8'h08
`define PCW_B_DRV 8'h09
`define PCW_A_IMC 8'h0a
`define PCW_B_IMC 8'h0b
`define PCW_A_OEN 8'h0c
`define PCW_B_OEN 8'h0d
`define PCW_C_IN 8'h10
`define PCW_D_IN 8'h11
`define PCW_C_OUT 8'h14
`define PCW_D_OUT 8'h15
`define PCW_C_DIR 8'h16
`define PCW_D_DIR 8'h17
`define PCW_C_DRV 8'h18
`define PCW_D_DRV 8'h19
`define PCW_D_IMC 8'h1a
`define PCW_C_OEN 8'h1c
`define PCW_MC_A 8'h20
`define PCW_MC_B 8'h21
`define PCW_MASK_A 8'h22
`define PCW_MASK_B 8'h23
`define PCW_E_IN 8'h30
`define PCW_E_FUN 8'h32
`define PCW_E_OUT 8'h34
`define PCW_E_DIR 8'h36
`define PCW_E_DRV 8'h38
`define PCW_F_IN 8'h40
`define PCW_G_IN 8'h41
`define PCW_F_FUN 8'h42
`define PCW_G_FUN 8'h43
`define PCW_F_OUT 8'h44
`define PCW_G_OUT 8'h45
`define PCW_F_DIR 8'h46
`define PCW_G_DIR 8'h47
`define PCW_F_DRV 8'h48
`define PCW_G_DRV 8'h49
`define PCW_F_OEN 8'h4c
`define PCW_RST_BYTE 8'h00
`define PCW_UNMAPPED 8'h00
`endif

// *** pcw_pkg.sv ***
// Types shared by the port control register window.
// Assumes nothing beyond the defines header.
package pcw_pkg;
   // Per-port configuration bundle, seven ports A..G
   typedef struct packed {
      logic [7:0] out_latch;
      logic [7:0] dir;
      logic [7:0] drv;
      logic [7:0] fun;
   } pcw_port_cfg_t;

   // Pin level bundle for one port
   typedef struct packed {
      logic [7:0] oe;
      logic [7:0] dout;
      logic [7:0] od;
      logic [7:0] slew;
   } pcw_pin_drive_t;
endpackage

// *** pcw_port_window.sv ***
// Port control register window: seven 8-bit ports, macrocell access.
// Assumes a byte-wide synchronous host bus on i_mclk; pins are async.
// Pin outputs are registered, so pads follow a write two edges later.
`timescale 1ns/1ps
`include "pcw_defines.svh"

module pcw_port_window (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Host register access
   input wire logic i_win_sel,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // Latched address source for ports E, F, G
   input wire logic [7:0] i_lat_addr_e,
   input wire logic [7:0] i_lat_addr_f,
   input wire logic [7:0] i_lat_addr_g,
   // Input macrocell states from the logic array
   input wire logic [7:0] i_imc_a,
   input wire logic [7:0] i_imc_b,
   input wire logic [7:0] i_imc_d,
   // Port pins A..G, index 0 is A
   input wire logic [7:0] i_pin [7],
   output logic [7:0] o_pin_out [7],
   output logic [7:0] o_pin_oe [7],
   output logic [7:0] o_pin_slew [7],
   // Output macrocells
   output logic [7:0] o_mc_a,
   output logic [7:0] o_mc_b
);
   localparam int PA = 0;
   localparam int PB = 1;
   localparam int PC = 2;
   localparam int PD = 3;
   localparam int PE = 4;
   localparam int PF = 5;
   localparam int PG = 6;

   logic [7:0] port_latch [7];
   logic [7:0] port_dir [7];
   logic [7:0] port_drv [7];
   logic [7:0] port_fun [7];
   pcw_pkg::pcw_port_cfg_t cfg [7];
   pcw_pkg::pcw_pin_drive_t next_drive [7];
   logic cfg_wr;
   logic [7:0] pin_meta [7];
   logic [7:0] pin_sync [7];
   logic [7:0] mask_a;
   logic [7:0] mask_b;
   logic [7:0] drv_en [7];
   logic [7:0] next_rdata;
   logic wr_hit;

   // Fixed offset lookup: port index for a register group, or 7 if none
   function automatic int out_port(input logic [7:0] a);
      case (a)
         `PCW_A_OUT: out_port = PA;
         `PCW_B_OUT: out_port = PB;
         `PCW_C_OUT: out_port = PC;
         `PCW_D_OUT: out_port = PD;
         `PCW_E_OUT: out_port = PE;
         `PCW_F_OUT: out_port = PF;
         `PCW_G_OUT: out_port = PG;
         default: out_port = 7;
      endcase
   endfunction

   function automatic int dir_port(input logic [7:0] a);
      case (a)
         `PCW_A_DIR: dir_port = PA;
         `PCW_B_DIR: dir_port = PB;
         `PCW_C_DIR: dir_port = PC;
         `PCW_D_DIR: dir_port = PD;
         `PCW_E_DIR: dir_port = PE;
         `PCW_F_DIR: dir_port = PF;
         `PCW_G_DIR: dir_port = PG;
         default: dir_port = 7;
      endcase
   endfunction

   function automatic int drv_port(input logic [7:0] a);
      case (a)
         `PCW_A_DRV: drv_port = PA;
         `PCW_B_DRV: drv_port = PB;
         `PCW_C_DRV: drv_port = PC;
         `PCW_D_DRV: drv_port = PD;
         `PCW_E_DRV: drv_port = PE;
         `PCW_F_DRV: drv_port = PF;
         `PCW_G_DRV: drv_port = PG;
         default: drv_port = 7;
      endcase
   endfunction

   function automatic int fun_port(input logic [7:0] a);
      case (a)
         `PCW_E_FUN: fun_port = PE;
         `PCW_F_FUN: fun_port = PF;
         `PCW_G_FUN: fun_port = PG;
         default: fun_port = 7;
      endcase
   endfunction

   // Latched address bits of a port; ports without address mode get zero
   function automatic logic [7:0] addr_source(input int p,
      input logic [7:0] e, input logic [7:0] f, input logic [7:0] g);
      case (p)
         PE: addr_source = e;
         PF: addr_source = f;
         PG: addr_source = g;
         default: addr_source = 8'h00;
      endcase
   endfunction

   // Ports whose drive bit picks slew rate instead of open drain
   function automatic logic has_slew(input int p);
      has_slew = (p == PC) || (p == PF);
   endfunction

   // Host load of a macrocell bank; masked bits keep their old value
   function automatic logic [7:0] masked_load(input logic [7:0] old_val,
      input logic [7:0] new_val, input logic [7:0] mask);
      masked_load = (new_val & ~mask) | (old_val & mask);
   endfunction

   // Status offsets; a write there must never reach a register
   function automatic logic read_only(input logic [7:0] a);
      case (a)
         `PCW_A_IN: read_only = 1'b1;
         `PCW_B_IN: read_only = 1'b1;
         `PCW_C_IN: read_only = 1'b1;
         `PCW_D_IN: read_only = 1'b1;
         `PCW_E_IN: read_only = 1'b1;
         `PCW_F_IN: read_only = 1'b1;
         `PCW_G_IN: read_only = 1'b1;
         `PCW_A_IMC: read_only = 1'b1;
         `PCW_B_IMC: read_only = 1'b1;
         `PCW_D_IMC: read_only = 1'b1;
         `PCW_A_OEN: read_only = 1'b1;
         `PCW_B_OEN: read_only = 1'b1;
         `PCW_C_OEN: read_only = 1'b1;
         `PCW_F_OEN: read_only = 1'b1;
         default: read_only = 1'b0;
      endcase
   endfunction

   // Only writes inside the selected window count
   assign wr_hit = i_win_sel & i_wr;
   // Screened explicitly so a future offset overlap cannot leak a write
   assign cfg_wr = wr_hit & ~read_only(i_addr);

   // Two-stage synchroniser on every pin
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 7; p++) begin
            pin_meta[p] <= `PCW_RST_BYTE;
            pin_sync[p] <= `PCW_RST_BYTE;
         end
      end else begin
         for (int p = 0; p < 7; p++) begin
            pin_meta[p] <= i_pin[p];
            pin_sync[p] <= pin_meta[p];
         end
      end
   end

   // Output latches
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 7; p++) begin
            port_latch[p] <= `PCW_RST_BYTE;
         end
      end else if (cfg_wr) begin
         for (int p = 0; p < 7; p++) begin
            if (out_port(i_addr) == p) begin
               port_latch[p] <= i_wdata;
            end
         end
      end
   end

   // Direction; reset leaves every pin an input
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 7; p++) begin
            port_dir[p] <= `PCW_RST_BYTE;
         end
      end else if (cfg_wr) begin
         for (int p = 0; p < 7; p++) begin
            if (dir_port(i_addr) == p) begin
               port_dir[p] <= i_wdata;
            end
         end
      end
   end

   // Drive type: open drain or slew rate, depending on the port
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 7; p++) begin
            port_drv[p] <= `PCW_RST_BYTE;
         end
      end else if (cfg_wr) begin
         for (int p = 0; p < 7; p++) begin
            if (drv_port(i_addr) == p) begin
               port_drv[p] <= i_wdata;
            end
         end
      end
   end

   // Address-mode select; only E, F and G decode an offset
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 7; p++) begin
            port_fun[p] <= `PCW_RST_BYTE;
         end
      end else if (cfg_wr) begin
         for (int p = 0; p < 7; p++) begin
            if (fun_port(i_addr) == p) begin
               port_fun[p] <= i_wdata;
            end
         end
      end
   end

   // Bundle the four settings of each port for the driver logic
   always_comb begin
      for (int p = 0; p < 7; p++) begin
         cfg[p].out_latch = port_latch[p];
         cfg[p].dir = port_dir[p];
         cfg[p].drv = port_drv[p];
         cfg[p].fun = port_fun[p];
      end
   end

   // Write mask of bank A
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_a <= `PCW_RST_BYTE;
      end else if (cfg_wr && i_addr == `PCW_MASK_A) begin
         mask_a <= i_wdata;
      end
   end

   // Write mask of bank B
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_b <= `PCW_RST_BYTE;
      end else if (cfg_wr && i_addr == `PCW_MASK_B) begin
         mask_b <= i_wdata;
      end
   end

   // Bank A macrocells; only host writes load them here
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mc_a <= `PCW_RST_BYTE;
      end else if (cfg_wr && i_addr == `PCW_MC_A) begin
         o_mc_a <= masked_load(o_mc_a, i_wdata, mask_a);
      end
   end

   // Bank B macrocells
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mc_b <= `PCW_RST_BYTE;
      end else if (cfg_wr && i_addr == `PCW_MC_B) begin
         o_mc_b <= masked_load(o_mc_b, i_wdata, mask_b);
      end
   end

   // Next drive of each pin; address mode drives regardless of direction
   always_comb begin
      logic [7:0] addr_bits;
      addr_bits = 8'h00;
      for (int p = 0; p < 7; p++) begin
         addr_bits = addr_source(p, i_lat_addr_e, i_lat_addr_f,
            i_lat_addr_g);
         next_drive[p].dout = (cfg[p].fun & addr_bits) |
            (~cfg[p].fun & cfg[p].out_latch);
         drv_en[p] = cfg[p].fun | cfg[p].dir;
         if (has_slew(p)) begin
            next_drive[p].od = 8'h00;
            next_drive[p].slew = cfg[p].drv;
         end else begin
            next_drive[p].od = cfg[p].drv;
            next_drive[p].slew = 8'h00;
         end
         // Open drain drives only a low, so a high output floats
         next_drive[p].oe = drv_en[p] & ~(next_drive[p].od &
            next_drive[p].dout);
      end
   end

   // Pads see registered levels, one cycle behind the settings
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 7; p++) begin
            o_pin_out[p] <= `PCW_RST_BYTE;
            o_pin_oe[p] <= `PCW_RST_BYTE;
            o_pin_slew[p] <= `PCW_RST_BYTE;
         end
      end else begin
         for (int p = 0; p < 7; p++) begin
            o_pin_out[p] <= next_drive[p].dout;
            o_pin_oe[p] <= next_drive[p].oe;
            o_pin_slew[p] <= next_drive[p].slew;
         end
      end
   end

   // Read decode; unmapped and write-only-absent offsets read zero
   always_comb begin
      next_rdata = `PCW_UNMAPPED;
      case (i_addr)
         `PCW_A_IN: next_rdata = pin_sync[PA];
         `PCW_B_IN: next_rdata = pin_sync[PB];
         `PCW_C_IN: next_rdata = pin_sync[PC];
         `PCW_D_IN: next_rdata = pin_sync[PD];
         `PCW_E_IN: next_rdata = pin_sync[PE];
         `PCW_F_IN: next_rdata = pin_sync[PF];
         `PCW_G_IN: next_rdata = pin_sync[PG];
         `PCW_A_IMC: next_rdata = i_imc_a;
         `PCW_B_IMC: next_rdata = i_imc_b;
         `PCW_D_IMC: next_rdata = i_imc_d;
         `PCW_A_OEN: next_rdata = drv_en[PA];
         `PCW_B_OEN: next_rdata = drv_en[PB];
         `PCW_C_OEN: next_rdata = drv_en[PC];
         `PCW_F_OEN: next_rdata = drv_en[PF];
         `PCW_MC_A: next_rdata = o_mc_a;
         `PCW_MC_B: next_rdata = o_mc_b;
         `PCW_MASK_A: next_rdata = mask_a;
         `PCW_MASK_B: next_rdata = mask_b;
         `PCW_E_FUN: next_rdata = cfg[PE].fun;
         `PCW_F_FUN: next_rdata = cfg[PF].fun;
         `PCW_G_FUN: next_rdata = cfg[PG].fun;
         default: begin
            if (out_port(i_addr) != 7) begin
               next_rdata = cfg[out_port(i_addr)].out_latch;
            end else if (dir_port(i_addr) != 7) begin
               next_rdata = cfg[dir_port(i_addr)].dir;
            end else if (drv_port(i_addr) != 7) begin
               next_rdata = cfg[drv_port(i_addr)].drv;
            end
         end
      endcase
   end

   // Read data registered one cycle after the read strobe
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= `PCW_RST_BYTE;
      end else if (i_win_sel && i_rd) begin
         o_rdata <= next_rdata;
      end
   end
endmodule

// *** pcw_pin_model.sv ***
// Pin-side model: resolves each pin from our driver and the outside level.
// Assumes the outside world drives i_ext wherever our driver is off.
`timescale 1ns/1ps
module pcw_pin_model (
   // Driver side
   input wire logic [7:0] i_out [7],
   input wire logic [7:0] i_oe [7],
   // Outside levels and resolved pins
   input wire logic [7:0] i_ext [7],
   output logic [7:0] o_pin [7]
);
   always_comb begin
      for (int p = 0; p < 7; p++) begin
         o_pin[p] = (i_out[p] & i_oe[p]) | (i_ext[p] & ~i_oe[p]);
      end
   end
endmodule

// *** pcw_port_window_properties.sv ***
// Checker for the port control register window, bound to its top.
// Assumes only host writes load the bank A macrocells.
`timescale 1ns/1ps
`include "pcw_defines.svh"
module pcw_port_window_properties (
   // Clock, reset and host bus
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_win_sel,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   // Pins and macrocells
   input wire logic [7:0] o_pin_out [7],
   input wire logic [7:0] o_pin_oe [7],
   input wire logic [7:0] o_pin_slew [7],
   input wire logic [7:0] o_mc_a
);
   logic [7:0] mask_a;
   logic wr_en;
   logic rd_en;
   assign wr_en = i_win_sel & i_wr;
   assign rd_en = i_win_sel & i_rd;
   // Mask is not visible at the ports, so keep a shadow
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_a <= 8'h00;
      end else if (wr_en && i_addr == `PCW_MASK_A) begin
         mask_a <= i_wdata;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   chk_slew_only_cf: assert property (o_pin_slew[0] == 8'h00 &&
      o_pin_slew[1] == 8'h00 && o_pin_slew[3] == 8'h00 &&
      o_pin_slew[4] == 8'h00 && o_pin_slew[6] == 8'h00)
      else $error("slew set on a port without it");
   chk_reset_inputs: assert property ($rose(i_rst_n) |->
      o_pin_oe[0] == 8'h00 && o_pin_oe[2] == 8'h00)
      else $error("driver on after reset");
   chk_dir_enable: assert property (wr_en && i_addr == `PCW_C_DIR |=>
      ##1 o_pin_oe[2] == $past(i_wdata, 2))
      else $error("enable not direction");
   chk_latch_drive: assert property (wr_en && i_addr == `PCW_C_OUT |=>
      ##1 ((o_pin_out[2] ^ $past(i_wdata, 2)) & o_pin_oe[2]) == 8'h00)
      else $error("pin not driven from latch");
   chk_mc_masked: assert property (wr_en && i_addr == `PCW_MC_A |=>
      o_mc_a == (($past(o_mc_a) & $past(mask_a)) |
      ($past(i_wdata) & ~$past(mask_a)))) else $error("mask not obeyed");
   chk_mc_read: assert property (rd_en && i_addr == `PCW_MC_A |=>
      o_rdata == $past(o_mc_a)) else $error("macrocell read wrong");
   chk_ro_write: assert property (wr_en && i_addr == `PCW_A_IN &&
      !$past(wr_en) ##1 !wr_en |=> $stable(o_pin_oe[0]) &&
      o_mc_a == $past(o_mc_a, 2))
      else $error("read-only write changed state");
   chk_unmapped_zero: assert property (rd_en && i_addr == 8'hff |=>
      o_rdata == 8'h00) else $error("unmapped read not zero");
   chk_rdata_holds: assert property (!rd_en |=> $stable(o_rdata))
      else $error("read data moved without a read");
   cover property (wr_en && i_addr == `PCW_MC_A && mask_a != 8'h00);
   cover property (rd_en && i_addr == `PCW_A_IN);
   cover property (o_pin_oe[4] == 8'hff);
endmodule
bind pcw_port_window pcw_port_window_properties
   pcw_port_window_properties_inst (.i_mclk, .i_rst_n, .i_win_sel, .i_addr,
   .i_wr, .i_rd, .i_wdata, .o_rdata, .o_pin_out, .o_pin_oe, .o_pin_slew,
   .o_mc_a);

// *** testbench.sv ***
// Self-checking bench for the port control register window.
// Assumes the pin model returns ext on every pin that is not driven.
`timescale 1ns/1ps
`include "pcw_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
   err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
   logic clk = 0, rst_n = 0, sel = 0, wr = 0, rd = 0;
   logic [7:0] addr = 0, wd = 0, la = 0, imc = 0, rdata, mc_a, mc_b;
   logic [7:0] ext [7] = '{default: 8'h00};
   logic [7:0] pin [7], po [7], oe [7], slew [7];
   logic [7:0] rw [26] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h22, 8'h23, 8'h32,
      8'h34, 8'h36, 8'h38, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
      8'h48, 8'h49};
   logic [7:0] ins [7] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h30, 8'h40,
      8'h41};
   int err_count = 0, tests_run = 0;
   pcw_port_window pcw_port_window_inst (.i_mclk(clk), .i_rst_n(rst_n),
      .i_win_sel(sel), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wd),
      .o_rdata(rdata), .i_lat_addr_e(la), .i_lat_addr_f(~la),
      .i_lat_addr_g(la ^ 8'h0f), .i_imc_a(imc), .i_imc_b(~imc),
      .i_imc_d(imc ^ 8'h0f), .i_pin(pin), .o_pin_out(po), .o_pin_oe(oe),
      .o_pin_slew(slew), .o_mc_a(mc_a), .o_mc_b(mc_b));
   pcw_pin_model pcw_pin_model_inst (.i_out(po), .i_oe(oe), .i_ext(ext),
      .o_pin(pin));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      sel <= 1'b1;
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      sel <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
      // Pads are registered, so let them settle before any compare
      @(posedge clk);
   endtask
   task automatic rd8(input logic [7:0] a, input logic [7:0] e,
      input string n);
      sel <= 1'b1;
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      sel <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
      `CHK(n, e, rdata)
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      results();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rw[i]) rd8(rw[i], 8'h00, "reset");
      foreach (rw[i]) begin
         wr8(rw[i], rw[i] ^ 8'ha5);
         rd8(rw[i], rw[i] ^ 8'ha5, "readback");
      end
      foreach (rw[i]) wr8(rw[i], 8'h00);
      $display("test registers done");
      foreach (ext[p]) ext[p] <= 8'h96 ^ 8'(p);
      imc <= 8'h3c;
      repeat (3) @(posedge clk);
      foreach (ins[p]) rd8(ins[p], 8'h96 ^ 8'(p), "pin level");
      wr8(`PCW_A_IMC, 8'hff);
      rd8(`PCW_A_IMC, 8'h3c, "imc a");
      rd8(`PCW_B_IMC, 8'hc3, "imc b");
      rd8(`PCW_D_IMC, 8'h33, "imc d");
      $display("test inputs done");
      wr8(`PCW_A_OUT, 8'h3c);
      wr8(`PCW_A_DIR, 8'hf0);
      `CHK("oe a", 8'hf0, oe[0])
      `CHK("out a", 8'h30, po[0] & oe[0])
      rd8(`PCW_A_OEN, 8'hf0, "enable a");
      wr8(`PCW_A_DRV, 8'hff);
      `CHK("drain a", 8'hc0, oe[0])
      wr8(`PCW_A_OEN, 8'h00);
      wr8(`PCW_A_IN, 8'hff);
      `CHK("ro oe a", 8'hc0, oe[0])
      wr8(`PCW_C_DRV, 8'h3c);
      wr8(`PCW_F_DRV, 8'h81);
      `CHK("slew c", 8'h3c, slew[2])
      `CHK("slew f", 8'h81, slew[5])
      `CHK("slew a", 8'h00, slew[0])
      la <= 8'ha5;
      wr8(`PCW_E_FUN, 8'hff);
      wr8(`PCW_F_FUN, 8'hff);
      wr8(`PCW_G_FUN, 8'hff);
      `CHK("addr e", 8'ha5, po[4])
      `CHK("addr f", 8'h5a, po[5])
      `CHK("addr g", 8'haa, po[6])
      `CHK("oe e", 8'hff, oe[4])
      rd8(`PCW_F_OEN, 8'hff, "enable f");
      $display("test drivers done");
      wr8(`PCW_MASK_A, 8'h0f);
      wr8(`PCW_MC_A, 8'hff);
      `CHK("mc a", 8'hf0, mc_a)
      rd8(`PCW_MC_A, 8'hf0, "mc a read");
      wr8(`PCW_MC_B, 8'h5a);
      `CHK("mc b", 8'h5a, mc_b)
      wr8(`PCW_MASK_B, 8'hf0);
      wr8(`PCW_MC_B, 8'hff);
      `CHK("mc b masked", 8'h5f, mc_b)
      rd8(`PCW_MC_B, 8'h5f, "mc b read");
      rd8(8'hff, 8'h00, "unmapped");
      $display("test macrocells done");
      results();
   end
endmodule
